// ### rtl/uis_top.sv
// interrupt status register of the usb peripheral, with enable gating and write-one-clear.
// assumes a synchronous register port on clk_in; pin-level status inputs are synchronised here.
`timescale 1ns/10ps
module uis_top
  import uis_pkg::*;
#(
  parameter int unsigned FS_TICK  = uis_pkg::FS_TICK_CYCLES,
  parameter int unsigned HS_TICK  = uis_pkg::HS_TICK_CYCLES,
  parameter int unsigned SE0_HOLD = uis_pkg::SE0_HOLD_CYCLES
)
(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic          reg_write_in,
  input  wire logic          reg_read_in,
  input  wire logic [31:0]   reg_wdata_in,
  output logic      [31:0]   reg_rdata_out,
  input  wire logic [31:0]   interrupt_enable_in,
  input  wire logic          bus_power_in,
  input  wire logic          suspended_in,
  input  wire logic          high_speed_in,
  input  wire logic          se0_in,
  input  wire logic          otg_enable_in,
  input  wire logic          dma_reason_change_in,
  input  wire logic          frame_start_in,
  input  wire logic          bus_reset_in,
  input  wire logic [15:0]   endpoint_event_in,
  input  wire logic          control_setup_in,
  output logic               interrupt_out
);
  import uis_pkg::*;

  // two-stage synchronisers for pin-level inputs
  logic [3:0] sync1, sync2;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end
    else
    begin
      sync1 <= {bus_power_in, suspended_in, high_speed_in, se0_in};
      sync2 <= sync1;
    end
  end

  uis_event_if ev ();

  uis_event_detect #(
    .FS_TICK  (FS_TICK),
    .HS_TICK  (HS_TICK),
    .SE0_HOLD (SE0_HOLD)
  ) u_detect (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .bus_power_in         (sync2[3]),
    .suspended_in         (sync2[2]),
    .high_speed_in        (sync2[1]),
    .dma_reason_change_in (dma_reason_change_in),
    .frame_start_in       (frame_start_in),
    .bus_reset_in         (bus_reset_in),
    .otg_enable_in        (otg_enable_in),
    .se0_in               (sync2[0]),
    .endpoint_event_in    (endpoint_event_in),
    .control_setup_in     (control_setup_in),
    .ev                   (ev)
  );

  function automatic logic hits_status(input logic [7:0] addr);
    hits_status = (addr == INTERRUPT_STATUS_OFFSET);
  endfunction

  logic [31:0] status, next_status;
  logic [31:0] clear_mask;
  logic [31:0] rdata, next_rdata;
  logic        irq, next_irq;

  always_comb
  begin
    clear_mask = (reg_write_in && hits_status(reg_addr_in)) ? reg_wdata_in : 32'h0000_0000;
    // set wins over a same-cycle clear
    next_status = ((status & ~clear_mask) | ev.set_pulse) & IMPLEMENTED_MASK;
    // bus_reset_in drops every other flag and leaves bus reset set, even in otg mode; the otg se0 reset only sets the flag
    if (bus_reset_in)
      next_status = STATUS_BUS_RESET | (ev.set_pulse & STATUS_BUS_RESET);
    next_irq   = |(next_status & interrupt_enable_in);
    next_rdata = reg_rdata_out;
    if (reg_read_in)
      next_rdata = hits_status(reg_addr_in) ? (status & IMPLEMENTED_MASK) : 32'h0000_0000;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      status <= STATUS_RESET;
      irq    <= 1'b0;
      rdata  <= 32'h0000_0000;
    end
    else
    begin
      status <= next_status;
      irq    <= next_irq;
      rdata  <= next_rdata;
    end
  end

  assign reg_rdata_out = rdata;
  assign interrupt_out = irq;

  sequence clear_write_s;
    reg_write_in && hits_status(reg_addr_in) && reg_wdata_in[BIT_DMA] && !ev.set_pulse[BIT_DMA]
      && !bus_reset_in;
  endsequence

  w1c_clear_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clear_write_s |=> !status[BIT_DMA])
    else $error("write one did not clear flag");
  zero_write_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (reg_write_in && status[BIT_CONTROL_SETUP] && !reg_wdata_in[BIT_CONTROL_SETUP]
      && !bus_reset_in) |=> status[BIT_CONTROL_SETUP])
    else $error("write zero disturbed flag");
  sticky_set_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ev.set_pulse[BIT_FRAME_START] && !bus_reset_in) |=> status[BIT_FRAME_START])
    else $error("event not latched");
  irq_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    interrupt_out == |(status & $past(interrupt_enable_in)))
    else $error("interrupt output mismatch");
  irq_follow_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (|(status & interrupt_enable_in) && $stable(interrupt_enable_in) && $stable(status))
      |-> interrupt_out)
    else $error("interrupt missing for enabled flag");
  bus_reset_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    bus_reset_in |=> status == STATUS_BUS_RESET)
    else $error("bus reset state wrong");
  reserved_zero_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (status & ~IMPLEMENTED_MASK) == 32'h0000_0000)
    else $error("reserved bit set");
  setup_flag_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (control_setup_in && !bus_reset_in) |=> status[BIT_CONTROL_SETUP])
    else $error("setup flag not set");
  endpoint_flag_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (endpoint_event_in[15] && !bus_reset_in) |=> status[25])
    else $error("endpoint 7 in flag not set");
endmodule

// ### rtl/uis_pkg.sv
// package of the usb interrupt status block: offsets, bit positions, reset values, timing.
// assumes a 25 MHz core clock; shared by the top module and the event detector.
package uis_pkg;
  localparam int unsigned  CLK_PERIOD_NS      = 40;
  localparam logic [7:0]   INTERRUPT_STATUS_OFFSET = 8'h18;
  localparam int unsigned  STATUS_WIDTH       = 32;
  localparam int unsigned  NUM_ENDPOINTS      = 8;
  localparam int unsigned  BIT_BUS_RESET      = 0;
  localparam int unsigned  BIT_FRAME_START    = 1;
  localparam int unsigned  BIT_PSEUDO_TICK    = 2;
  localparam int unsigned  BIT_SUSPEND        = 3;
  localparam int unsigned  BIT_RESUME         = 4;
  localparam int unsigned  BIT_HIGH_SPEED     = 5;
  localparam int unsigned  BIT_DMA            = 6;
  localparam int unsigned  BIT_BUS_POWER      = 7;
  localparam int unsigned  BIT_CONTROL_SETUP  = 8;
  localparam int unsigned  BIT_ENDPOINT_BASE  = 10;
  localparam logic [31:0]  STATUS_RESET       = 32'h0000_0000;
  localparam logic [31:0]  STATUS_BUS_RESET   = 32'h0000_0001;
  localparam logic [31:0]  IMPLEMENTED_MASK   = 32'h03FF_FDFF;
  localparam int unsigned  FS_TICK_NS         = 1000000;
  localparam int unsigned  HS_TICK_NS         = 125000;
  localparam int unsigned  SE0_HOLD_NS        = 2000000;
  localparam int unsigned  FS_TICK_CYCLES     = FS_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned  HS_TICK_CYCLES     = HS_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned  SE0_HOLD_CYCLES    = (SE0_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### rtl/uis_event_if.sv
// interface carrying one-cycle event pulses from the detector to the status register.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
interface uis_event_if;
  logic [31:0] set_pulse;
  modport source (output set_pulse);
  modport sink   (input  set_pulse);
endinterface

// ### rtl/uis_event_detect.sv
// event detector: edges of bus states, pseudo frame tick, gated bus reset.
// assumes all inputs already synchronised to clk_in.
`timescale 1ns/10ps
module uis_event_detect
  import uis_pkg::*;
#(
  parameter int unsigned FS_TICK  = FS_TICK_CYCLES,
  parameter int unsigned HS_TICK  = HS_TICK_CYCLES,
  parameter int unsigned SE0_HOLD = SE0_HOLD_CYCLES
)
(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          bus_power_in,
  input  wire logic          suspended_in,
  input  wire logic          high_speed_in,
  input  wire logic          dma_reason_change_in,
  input  wire logic          frame_start_in,
  input  wire logic          bus_reset_in,
  input  wire logic          otg_enable_in,
  input  wire logic          se0_in,
  input  wire logic [15:0]   endpoint_event_in,
  input  wire logic          control_setup_in,
  uis_event_if.source        ev
);
  initial
  begin
    if (FS_TICK < 2 || HS_TICK < 2 || SE0_HOLD < 2 ||
        FS_TICK >= (1 << 24) || HS_TICK >= (1 << 24) || SE0_HOLD >= (1 << 24))
      $error("uis_event_detect: counts out of range");
  end

  logic        power_q, suspend_flag_q, hs_q;
  logic        next_power_q, next_suspend_flag_q, next_hs_q;
  logic [23:0] tick_cnt, next_tick_cnt;
  logic [23:0] se0_cnt, next_se0_cnt;
  logic        tick, se0_done, bus_reset_ev;

  always_comb
  begin
    next_power_q = bus_power_in;
    next_suspend_flag_q  = suspended_in;
    next_hs_q    = high_speed_in;
    tick         = 1'b0;
    // free-running pseudo frame tick, period by current speed
    if (tick_cnt >= 24'((high_speed_in ? HS_TICK : FS_TICK) - 1))
    begin
      next_tick_cnt = 24'h00_0000;
      tick          = 1'b1;
    end
    else
      next_tick_cnt = tick_cnt + 24'h00_0001;
    // se0 persistence for otg mode; one event per continuous se0
    se0_done = 1'b0;
    if (!se0_in)
      next_se0_cnt = 24'h00_0000;
    else if (se0_cnt == 24'(SE0_HOLD - 1))
    begin
      next_se0_cnt = se0_cnt + 24'h00_0001;
      se0_done     = 1'b1;
    end
    else if (se0_cnt >= 24'(SE0_HOLD))
      next_se0_cnt = se0_cnt;
    else
      next_se0_cnt = se0_cnt + 24'h00_0001;
    bus_reset_ev = otg_enable_in ? se0_done : bus_reset_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      power_q  <= 1'b0;
      suspend_flag_q   <= 1'b0;
      hs_q     <= 1'b0;
      tick_cnt <= 24'h00_0000;
      se0_cnt  <= 24'h00_0000;
    end
    else
    begin
      power_q  <= next_power_q;
      suspend_flag_q   <= next_suspend_flag_q;
      hs_q     <= next_hs_q;
      tick_cnt <= next_tick_cnt;
      se0_cnt  <= next_se0_cnt;
    end
  end

  always_comb
  begin
    ev.set_pulse = 32'h0000_0000;
    ev.set_pulse[BIT_ENDPOINT_BASE +: 16] = endpoint_event_in;
    ev.set_pulse[BIT_CONTROL_SETUP] = control_setup_in;
    ev.set_pulse[BIT_BUS_POWER]     = bus_power_in & ~power_q;
    ev.set_pulse[BIT_DMA]           = dma_reason_change_in;
    ev.set_pulse[BIT_HIGH_SPEED]    = high_speed_in & ~hs_q & ~suspended_in;
    ev.set_pulse[BIT_RESUME]        = suspend_flag_q & ~suspended_in;
    ev.set_pulse[BIT_SUSPEND]       = suspended_in & ~suspend_flag_q;
    ev.set_pulse[BIT_PSEUDO_TICK]   = tick;
    ev.set_pulse[BIT_FRAME_START]   = frame_start_in;
    ev.set_pulse[BIT_BUS_RESET]     = bus_reset_ev;
  end

  bus_power_rise_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(bus_power_in) |-> ev.set_pulse[BIT_BUS_POWER])
    else $error("power rise not flagged");
  otg_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (otg_enable_in && ev.set_pulse[BIT_BUS_RESET]) |-> se0_cnt == 24'(SE0_HOLD - 1))
    else $error("otg bus reset before se0 hold");
  hs_suspend_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    suspended_in |-> !ev.set_pulse[BIT_HIGH_SPEED])
    else $error("speed flag during suspend");
endmodule

// ### dv/uis_host_model.sv
// host processor model: strobe register bus master for the interrupt status block.
// assumes the bench calls its tasks; signals change only after rising edges.
`timescale 1ns/10ps
module uis_host_model
(
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  output logic      [7:0]  addr_out,
  output logic             write_out,
  output logic             read_out,
  output logic      [31:0] wdata_out
);
  initial
  begin
    addr_out  = 8'h00;
    write_out = 1'b0;
    read_out  = 1'b0;
    wdata_out = 32'h0000_0000;
  end
  // released address and data show the inverse so stale values are never mistaken for valid
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    write_out <= 1'b1;
    @(posedge clk_in);
    write_out <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    read_out <= 1'b1;
    @(posedge clk_in);
    read_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rdata_in;
  endtask
  // source lookup: status masked with the enable value passed in en
  task automatic find_source(input logic [31:0] en, output logic [31:0] src);
    logic [31:0] s;
    read_reg(8'h18, s);
    src = s & en;
  endtask
endmodule

// ### dv/uis_top_bench.sv
// self-checking bench of the interrupt status block with a host model on the register port.
// assumes shortened tick and se0 counts; pseudo tick bit is masked out except in its own test.
`timescale 1ns/10ps
module uis_top_bench;
  import uis_pkg::*;
  localparam int unsigned FS_T = 8;
  localparam int unsigned SE0_T = 6;
  localparam logic [31:0] NO_TICK = 32'hFFFF_FFFB;
  logic clk_in = 1'b0, rst_n_in = 1'b0, bus_power_in = 1'b0, suspended_in = 1'b0;
  logic high_speed_in = 1'b0, se0_in = 1'b0, otg_enable_in = 1'b0, dma_in = 1'b0;
  logic frame_in = 1'b0, bus_reset_in = 1'b0, setup_in = 1'b0, interrupt_out;
  logic [15:0] ep_in = 16'h0000;
  logic [31:0] enable_in = NO_TICK, rdata, s;
  logic [7:0]  addr;
  logic        wr, rd;
  logic [31:0] wdata;
  int failures = 0, cmp_count = 0, cycles = 0;
  always #20 clk_in = ~clk_in;
  uis_top #(.FS_TICK(FS_T), .HS_TICK(4), .SE0_HOLD(SE0_T)) uis_top_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_write_in(wr),
    .reg_read_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .interrupt_enable_in(enable_in), .bus_power_in(bus_power_in),
    .suspended_in(suspended_in), .high_speed_in(high_speed_in), .se0_in(se0_in),
    .otg_enable_in(otg_enable_in), .dma_reason_change_in(dma_in), .frame_start_in(frame_in),
    .bus_reset_in(bus_reset_in), .endpoint_event_in(ep_in), .control_setup_in(setup_in),
    .interrupt_out(interrupt_out));
  uis_host_model uis_host_model_i (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .write_out(wr), .read_out(rd), .wdata_out(wdata));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic status_is(input string name, input logic [31:0] exp);
    uis_host_model_i.read_reg(8'h18, s);
    check(name, s & NO_TICK, exp);
  endtask
  task automatic t_endpoints();
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_in) ep_in <= 16'h0001 << i;
      @(posedge clk_in) ep_in <= 16'h0000;
      status_is("endpoint set", 32'h0000_0400 << i);
      uis_host_model_i.write_reg(8'h18, 32'h0000_0400 << i);
      status_is("endpoint clear", 32'h0000_0000);
    end
  endtask
  task automatic t_sources();
    logic [31:0] exp_t [9] = '{32'h100, 32'h40, 32'h2, 32'h80, 32'h0, 32'h20, 32'h8, 32'h0, 32'h10};
    for (int k = 0; k < 9; k++)
    begin
      @(posedge clk_in);
      case (k)
        0: setup_in <= 1'b1;
        1: dma_in <= 1'b1;
        2: frame_in <= 1'b1;
        3: bus_power_in <= 1'b1;
        4: bus_power_in <= 1'b0;
        5: high_speed_in <= 1'b1;
        6: suspended_in <= 1'b1;
        7: high_speed_in <= 1'b0;
        default: suspended_in <= 1'b0;
      endcase
      @(posedge clk_in) {setup_in, dma_in, frame_in} <= 3'b000;
      wait_n(4);
      status_is("source flag", exp_t[k]);
      check("irq level", {31'h0, interrupt_out}, {31'h0, exp_t[k] != 0});
      uis_host_model_i.write_reg(8'h18, exp_t[k]);
      status_is("source clear", 32'h0000_0000);
    end
  endtask
  task automatic t_dma_clear();
    @(posedge clk_in) dma_in <= 1'b1;
    @(posedge clk_in) dma_in <= 1'b0;
    status_is("dma set", 32'h0000_0040);
    fork
      uis_host_model_i.write_reg(8'h18, 32'h0000_0040);
      begin
        @(posedge clk_in) dma_in <= 1'b1;
        @(posedge clk_in) dma_in <= 1'b0;
      end
    join
    status_is("set beats clear", 32'h0000_0040);
    // a new reason change keeps the flag set, then a write of one to the dma bit clears it
    @(posedge clk_in) dma_in <= 1'b1;
    @(posedge clk_in) dma_in <= 1'b0;
    uis_host_model_i.write_reg(8'h18, 32'h0000_0040);
    status_is("dma clear", 32'h0000_0000);
  endtask
  task automatic t_access();
    @(posedge clk_in) {setup_in, frame_in} <= 2'b11;
    @(posedge clk_in) {setup_in, frame_in} <= 2'b00;
    uis_host_model_i.write_reg(8'h18, 32'h0000_0000);
    status_is("write zero", 32'h0000_0102);
    uis_host_model_i.write_reg(8'h1C, 32'hFFFF_FFFF);
    status_is("other address", 32'h0000_0102);
    uis_host_model_i.read_reg(8'h1C, s);
    check("unmapped read", s, 32'h0000_0000);
    @(posedge clk_in) enable_in <= 32'h0200_0000;
    wait_n(2);
    check("masked irq", {31'h0, interrupt_out}, 32'h0);
    uis_host_model_i.find_source(32'h0000_0002, s);
    check("source lookup", s, 32'h0000_0002);
    uis_host_model_i.write_reg(8'h18, 32'hFC00_0202);
    status_is("reserved bits", 32'h0000_0100);
    uis_host_model_i.write_reg(8'h18, 32'h0000_0100);
    @(posedge clk_in) enable_in <= NO_TICK;
  endtask
  task automatic t_resets();
    @(posedge clk_in) {setup_in, bus_reset_in} <= 2'b11;
    @(posedge clk_in) {setup_in, bus_reset_in} <= 2'b00;
    status_is("bus reset", 32'h0000_0001);
    uis_host_model_i.write_reg(8'h18, 32'h0000_0001);
    @(posedge clk_in) {otg_enable_in, se0_in} <= 2'b11;
    @(posedge clk_in) se0_in <= 1'b0;
    wait_n(SE0_T + 4);
    status_is("short se0", 32'h0000_0000);
    @(posedge clk_in) se0_in <= 1'b1;
    wait_n(SE0_T + 6);
    @(posedge clk_in) se0_in <= 1'b0;
    status_is("long se0", 32'h0000_0001);
    uis_host_model_i.write_reg(8'h18, 32'h0000_0005);
    wait_n(FS_T + 4);
    uis_host_model_i.read_reg(8'h18, s);
    check("pseudo tick", s & 32'h4, 32'h0000_0004);
    @(posedge clk_in) setup_in <= 1'b1;
    @(posedge clk_in) setup_in <= 1'b0;
    wait_n(1);
    check("irq before reset", {31'h0, interrupt_out}, 32'h1);
    @(posedge clk_in) rst_n_in <= 1'b0;
    wait_n(2);
    check("chip reset irq", {31'h0, interrupt_out}, 32'h0);
    @(posedge clk_in) rst_n_in <= 1'b1;
    status_is("chip reset", 32'h0000_0000);
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    wait_n(10);
    @(posedge clk_in) rst_n_in <= 1'b1;
    wait_n(3);
    status_is("reset value", 32'h0000_0000);
    t_endpoints();
    t_sources();
    t_dma_clear();
    t_access();
    t_resets();
    conclude();
  end
endmodule
